// >>> acc_defs.svh
// Constants of the comparator control block: offsets, bit positions,
// reset values and widths.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Bus decode
`define ACC_ADDR_W 8
`define ACC_OFS_CTRL 8'h00
`define ACC_OFS_STAT 8'h04
`define ACC_OFS_CLR 8'h08
`define ACC_OFS_IEN 8'h0C
`define ACC_RD_PAD 24'h000000
`define ACC_RD_ZERO 8'h00
`define ACC_HRDATA_RST 32'h00000000

// Control register fields
`define ACC_CTRL_W 8
`define ACC_B_EN 7
`define ACC_B_REF 6
`define ACC_B_FLAG 5
`define ACC_B_IE 4
`define ACC_B_RES 3
`define ACC_B_PIN 2
`define ACC_B_MODE_HI 1
`define ACC_B_MODE_LO 0
`define ACC_CTRL_RST 8'h00

// Event status, clear and enable registers
`define ACC_STAT_W 2
`define ACC_S_EVT 0
`define ACC_S_TGL 1
`define ACC_STAT_RST 2'h0
`define ACC_STAT_PAD 6'h00

// Power-up settling of the result path
`define ACC_SETTLE_W 3
`define ACC_SETTLE_CNT 3'h4
`define ACC_SETTLE_ZERO 3'h0
`define ACC_SETTLE_ONE 3'h1

`endif

// >>> acc_pkg.sv
// Types shared by the comparator control block.
// Assumes acc_defs.svh sits in the same folder.
`default_nettype none
`include "acc_defs.svh"

package acc_pkg;

  // Event mode field encodings
  typedef enum logic [1:0] {
    ACC_MODE_FALL = 2'h0,
    ACC_MODE_RISE = 2'h1,
    ACC_MODE_FALL2 = 2'h2,
    ACC_MODE_BOTH = 2'h3
  } acc_mode_t;

  typedef logic [`ACC_CTRL_W-1:0] acc_ctrl_t;
  typedef logic [`ACC_STAT_W-1:0] acc_stat_t;

endpackage
`default_nettype wire

// >>> acc_sync.sv
// Two-stage synchroniser with edge detection on the settled level.
// Assumes the input is asynchronous to clk and free of glitches
// shorter than a clock period.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"

module acc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic settled;
  logic prev;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      settled <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      settled <= meta;
      prev <= settled;
    end
  end

  // Edges of the settled level only
  assign level = settled;
  assign rise = settled & ~prev;
  assign fall = ~settled & prev;

endmodule
`default_nettype wire

// >>> acc_top.sv
// Comparator control block: one 8-bit control register, event status
// with its own interrupt mask, and the digital side of the comparator.
// Assumes an AHB-Lite master with single word transfers, an analog
// comparator core whose result arrives asynchronously, and a power
// controller that raises deep_stop on the bus clock.
// Limitation: result pulses shorter than one clock period may be lost.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"

module acc_top
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog core and pins
  input wire logic comparator_raw,
  input wire logic deep_stop,
  output logic comparator_power_en,
  output logic reference_select,
  output logic comparator_result_pin,
  output logic comparator_result_pin_oe,
  // Interrupt and wake
  output logic irq,
  output logic wake_request
);

  import acc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************

  logic blk_rst;
  logic acc_take;
  logic acc_wr;
  logic acc_rd;
  logic [`ACC_ADDR_W-1:0] wr_addr;
  logic wr_pend;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_ien;
  logic [`ACC_ADDR_W-1:0] rd_addr;
  logic [7:0] wbyte;
  logic [7:0] next_rbyte;
  logic [31:0] next_hrdata;

  acc_ctrl_t ctrl;
  acc_ctrl_t next_ctrl;
  acc_stat_t stat;
  acc_stat_t next_stat;
  acc_stat_t ien;
  acc_stat_t next_ien;
  acc_stat_t stat_set;
  acc_stat_t stat_clr;

  logic enable;
  logic next_enable;
  acc_mode_t mode;
  logic res_level;
  logic res_rise;
  logic res_fall;
  logic [`ACC_SETTLE_W-1:0] settle_cnt;
  logic [`ACC_SETTLE_W-1:0] next_settle_cnt;
  logic settled_ok;
  logic pick_rise;
  logic pick_fall;
  logic cmp_event;
  logic any_edge;
  logic flag_clr;
  logic next_flag;
  logic ctrl_irq;
  logic stat_irq;
  logic pin_value;
  logic pin_oe;

  // ****************************************************************
  // Reset and power
  // ****************************************************************

  // deep stop reset
  // Deep stop holds the block in reset, so the wake finds reset state
  assign blk_rst = srst | deep_stop;

  // comparator enable
  // Analog core powered only when enabled and not in deep stop
  assign enable = ctrl[`ACC_B_EN];
  assign comparator_power_en = enable & ~deep_stop;

  // reference select
  // Selects pin or bandgap on the non-inverting input
  assign reference_select = ctrl[`ACC_B_REF];

  // ****************************************************************
  // Result synchronisation and edge detection
  // ****************************************************************

  // result synchroniser
  // Result passes two flops before any logic looks at it
  acc_sync u_sync (
    .clk(core_clk),
    .rst(blk_rst),
    .async_in(comparator_raw),
    .level(res_level),
    .rise(res_rise),
    .fall(res_fall)
  );

  // result polarity
  // Result high means non-inverting above inverting; no inversion here
  assign mode = acc_mode_t'(ctrl[`ACC_B_MODE_HI:`ACC_B_MODE_LO]);

  // mode selection
  // Both falling codes share one path; 11 takes either edge
  assign pick_rise = (mode == ACC_MODE_RISE) || (mode == ACC_MODE_BOTH);
  assign pick_fall = (mode == ACC_MODE_FALL) || (mode == ACC_MODE_FALL2) ||
                     (mode == ACC_MODE_BOTH);

  // disabled gating
  // Edges count only once the settle counter below is full
  assign cmp_event = enable & settled_ok & ((pick_rise & res_rise) | (pick_fall & res_fall));
  assign any_edge = enable & settled_ok & (res_rise | res_fall);

  // power-up settling
  // Samples taken before the core was powered are garbage and
  // need three flops to drain: two synchroniser stages and the
  // edge history. The price is a short blind spot after enable.
  assign settled_ok = (settle_cnt == `ACC_SETTLE_CNT);
  assign next_settle_cnt = !enable ? `ACC_SETTLE_ZERO :
                           settled_ok ? settle_cnt :
                           settle_cnt + `ACC_SETTLE_ONE;

  // Settle counter, cleared while disabled
  always_ff @(posedge core_clk) begin
    if (blk_rst) begin
      settle_cnt <= `ACC_SETTLE_ZERO;
    end else begin
      settle_cnt <= next_settle_cnt;
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************

  // Never waits, never errors
  // Zero wait states keep a read right after a write simple
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase decode
  assign acc_take = hsel & hready & htrans[1];
  assign acc_wr = acc_take & hwrite;
  assign acc_rd = acc_take & ~hwrite;
  assign rd_addr = haddr[`ACC_ADDR_W-1:0];

  // Address phase capture for the following data phase
  // Reset by srst only: deep stop must not cut a transfer in flight
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_addr <= `ACC_OFS_CTRL;
    end else begin
      wr_pend <= acc_wr;
      wr_addr <= rd_addr;
    end
  end

  // Data phase write strobes; width of hsize ignored, low byte used
  // Unmapped offsets raise no strobe, so such writes vanish
  assign wbyte = hwdata[7:0];
  assign wr_ctrl = wr_pend & (wr_addr == `ACC_OFS_CTRL);
  assign wr_clr = wr_pend & (wr_addr == `ACC_OFS_CLR);
  assign wr_ien = wr_pend & (wr_addr == `ACC_OFS_IEN);

  // ****************************************************************
  // Control register
  // ****************************************************************

  // write one to clear
  // Only a written one at the flag position clears it
  assign flag_clr = wr_ctrl & wbyte[`ACC_B_FLAG];

  assign next_flag = cmp_event | (ctrl[`ACC_B_FLAG] & ~flag_clr);

  // readback read-only
  // Writable fields follow the bus; flag and readback never take data
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl[`ACC_B_EN] = wbyte[`ACC_B_EN];
      next_ctrl[`ACC_B_REF] = wbyte[`ACC_B_REF];
      next_ctrl[`ACC_B_IE] = wbyte[`ACC_B_IE];
      next_ctrl[`ACC_B_PIN] = wbyte[`ACC_B_PIN];
      next_ctrl[`ACC_B_MODE_HI:`ACC_B_MODE_LO] = wbyte[`ACC_B_MODE_HI:`ACC_B_MODE_LO];
    end
    next_ctrl[`ACC_B_FLAG] = next_flag;
    next_ctrl[`ACC_B_RES] = 1'b0;
  end

  // Control register storage
  always_ff @(posedge core_clk) begin
    if (blk_rst) begin
      ctrl <= `ACC_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ****************************************************************
  // Event status, clear and interrupt enable
  // ****************************************************************

  // Sticky event sources: selected compare event and any toggle
  // The toggle bit also catches edges the mode field filters out
  assign stat_set[`ACC_S_EVT] = cmp_event;
  assign stat_set[`ACC_S_TGL] = any_edge;
  assign stat_clr = wr_clr ? wbyte[`ACC_STAT_W-1:0] : `ACC_STAT_RST;

  // status set priority
  // Per bit, a new event outweighs a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `ACC_STAT_W; gi = gi + 1) begin : g_stat
      assign next_stat[gi] = stat_set[gi] | (stat[gi] & ~stat_clr[gi]);
    end
  endgenerate

  // Mask register, written whole
  assign next_ien = wr_ien ? wbyte[`ACC_STAT_W-1:0] : ien;

  // Status and mask storage
  always_ff @(posedge core_clk) begin
    if (blk_rst) begin
      stat <= `ACC_STAT_RST;
      ien <= `ACC_STAT_RST;
    end else begin
      stat <= next_stat;
      ien <= next_ien;
    end
  end

  // ****************************************************************
  // Interrupt and wake
  // ****************************************************************

  assign ctrl_irq = ctrl[`ACC_B_IE] & ctrl[`ACC_B_FLAG];
  assign stat_irq = |(stat & ien);

  // light stop wake
  // Logic keeps running on the bus clock in light stop; the request
  // itself doubles as the wake, so no separate path is needed
  always_ff @(posedge core_clk) begin
    if (blk_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl_irq | stat_irq;
    end
  end

  // Wake shares the registered request
  assign wake_request = irq;

  // ****************************************************************
  // Result pin
  // ****************************************************************

  // result pin drive
  // Pin driven only while enabled and pin output selected
  // Disabled core output is meaningless, hence the enable term
  assign pin_oe = ctrl[`ACC_B_PIN] & enable;
  assign pin_value = pin_oe & res_level;

  // Registered pin drive keeps the pin free of decode glitches
  // Costs one cycle of latency between result and pin
  always_ff @(posedge core_clk) begin
    if (blk_rst) begin
      comparator_result_pin <= 1'b0;
      comparator_result_pin_oe <= 1'b0;
    end else begin
      comparator_result_pin <= pin_value;
      comparator_result_pin_oe <= pin_oe;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  // live result
  // Read mux uses next values so a read right after a write sees it
  // Readback follows the synchroniser, two cycles behind the raw result
  assign next_enable = next_ctrl[`ACC_B_EN];

  always_comb begin
    next_rbyte = `ACC_RD_ZERO;
    case (rd_addr)
      `ACC_OFS_CTRL: begin
        next_rbyte = next_ctrl;
        next_rbyte[`ACC_B_RES] = next_enable & res_level;
      end
      `ACC_OFS_STAT: begin
        next_rbyte = {`ACC_STAT_PAD, next_stat};
      end
      `ACC_OFS_IEN: begin
        next_rbyte = {`ACC_STAT_PAD, next_ien};
      end
      default: begin
        next_rbyte = `ACC_RD_ZERO; // Clear register and holes read zero
      end
    endcase
  end

  assign next_hrdata = acc_rd ? {`ACC_RD_PAD, next_rbyte} : hrdata;

  // Read data stands through the data phase
  // Bus side ignores deep stop so a read in flight still completes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= `ACC_HRDATA_RST;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule
`default_nettype wire

// >>> acc_checker.sv
// Port checker for the comparator control block.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ps
`default_nettype none
// ************
// Checker
// ************
module acc_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [31:0] hwdata,
  input wire logic comparator_raw,
  input wire logic deep_stop,
  input wire logic comparator_power_en,
  input wire logic reference_select,
  input wire logic comparator_result_pin,
  input wire logic comparator_result_pin_oe,
  input wire logic irq,
  input wire logic wake_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Deep stop seen, one cycle for its reset to land
  sequence deep_held;
    deep_stop ##1 1'b1;
  endsequence
  // Raw level that the pin shows: two sync stages plus the pin flop
  sequence raw_settled;
    $past(comparator_raw, 3);
  endsequence
  wake_irq_a: assert property (wake_request == irq)
    else $error("wake differs from irq");
  deep_off_a: assert property (deep_stop |-> !comparator_power_en)
    else $error("powered in deep stop");
  deep_reset_a: assert property (deep_held |-> !irq && !reference_select && !comparator_result_pin_oe)
    else $error("not reset after deep stop");
  power_rise_a: assert property ($rose(comparator_power_en) |-> $past(hwdata[7]))
    else $error("power without enable write");
  ref_write_a: assert property ($changed(reference_select) && !$past(deep_stop) && !$past(srst)
    |-> reference_select == $past(hwdata[6]))
    else $error("select differs from write");
  oe_power_a: assert property ($rose(comparator_result_pin_oe) |-> comparator_power_en)
    else $error("pin enabled while off");
  pin_idle_a: assert property (!comparator_result_pin_oe |-> !comparator_result_pin)
    else $error("pin driven while off");
  pin_follow_a: assert property ($rose(comparator_result_pin) && $past(comparator_power_en, 4)
    |-> raw_settled)
    else $error("pin rose without result");
endmodule

bind acc_top acc_checker u_checker (.core_clk, .srst, .hwdata, .comparator_raw, .deep_stop, .comparator_power_en,
  .reference_select, .comparator_result_pin, .comparator_result_pin_oe, .irq, .wake_request);
`default_nettype wire

// >>> acc_partner.sv
// Behavioural analog comparator core with its input pins.
// Assumes voltages in millivolts from the bench, sampled on the bus clock.
`timescale 1ns/1ps
`default_nettype none
// ************
// Comparator core
// ************
module acc_partner (
  input wire logic core_clk,
  input wire logic power_en,
  input wire logic ref_sel,
  input wire logic [11:0] pos_mv,
  input wire logic [11:0] neg_mv,
  input wire logic [11:0] gap_mv,
  output logic raw
);
  logic [11:0] plus_mv;
  assign plus_mv = ref_sel ? gap_mv : pos_mv;
  initial raw = 1'b0;
  // compare while powered; unpowered output wanders
  always @(posedge core_clk) begin
    raw <= power_en ? (plus_mv > neg_mv) : ~raw;
  end
endmodule
`default_nettype wire

// >>> tb_comparator_control_logic.sv
// Self-checking bench for the comparator control block.
// Assumes acc_top, acc_partner and the bound checker compiled first.
`timescale 1ns/1ps
`default_nettype none
// ************
// Bench top
// ************
module tb_comparator_control_logic;
  logic core_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, deep_stop = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata, r;
  logic hreadyout, hresp, raw, pwr, rsel, pin, oe, irq, wake;
  logic [11:0] vp = 12'h000, vg = 12'h000;
  int num_errors = 0, n_compared = 0, cyc = 0;
  int cfg, flag, stat, ien, prev, m;

  acc_top dut (.core_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .comparator_raw(raw), .deep_stop, .comparator_power_en(pwr),
    .reference_select(rsel), .comparator_result_pin(pin), .comparator_result_pin_oe(oe), .irq,
    .wake_request(wake));
  acc_partner u_core (.core_clk, .power_en(pwr), .ref_sel(rsel), .pos_mv(vp), .neg_mv(12'h800), .gap_mv(vg),
    .raw);

  // Free-running bus clock, 8 ns
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Ceiling so a stuck handshake still ends the run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Input level above or below the 2048 mV inverting input
  function automatic logic [11:0] lvl(input int hi);
    return hi ? 12'h801 + 12'($urandom % 1000) : 12'($urandom % 2048);
  endfunction

  task automatic clr();
    ahb(1, 8'h00, cfg | 'h20);
    ahb(1, 8'h08, 3);
    flag = 0;
    stat = 0;
  endtask

  // Move the result, update the model, compare every result
  task automatic step(input int hi);
    int en, ev, ei;
    en = cfg >> 7 & 1;
    vg <= (cfg & 'h40) ? lvl(hi) : lvl(!hi);
    vp <= (cfg & 'h40) ? lvl(!hi) : lvl(hi);
    repeat (8) @(posedge core_clk);
    ev = (cfg & 3) == 3 || ((cfg & 3) == 1) == (hi == 1);
    if (en && hi != prev) begin
      flag |= ev;
      stat |= 2 | ev;
    end
    prev = hi;
    ahb(0, 8'h00, 0);
    chk(r, (cfg & 'hD7) | flag << 5 | (en & hi) << 3);
    ahb(0, 8'h04, 0);
    chk(r, stat);
    ei = (cfg >> 4 & flag & 1) != 0 || (stat & ien) != 0;
    chk_pin(irq, ei);
    chk_pin(wake, ei);
    chk_pin(pin, (cfg & 'h84) == 'h84 && hi);
    chk_pin(oe, (cfg & 'h84) == 'h84);
    chk_pin(pwr, en != 0);
    chk_pin(rsel, (cfg & 'h40) != 0);
    chk_pin(hresp, 1'b0);
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reset values, every mode with random settings, disable, deep stop
  initial begin
    void'($urandom(32'h48835CAA));
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    for (m = 0; m < 5; m++) begin
      ahb(0, 8'(m * 4), 0);
      chk(r, 0);
    end
    for (m = 0; m < 8; m++) begin
      ien = $urandom % 4;
      cfg = 'h8C | ($urandom % 2) << 6 | ($urandom % 2) << 4 | m % 4;
      ahb(1, 8'h0C, ien);
      ahb(0, 8'h0C, 0);
      chk(r, ien);
      ahb(1, 8'h00, cfg);
      vp <= lvl(0);
      vg <= lvl(0);
      repeat (8) @(posedge core_clk);
      clr();
      prev = 0;
      step(1);
      ahb(1, 8'h00, cfg);
      step(1);
      step(0);
      clr();
      step(0);
    end
    cfg = 'h03;
    clr();
    step(1);
    step(0);
    ahb(1, 8'h00, 'hD7);
    deep_stop <= 1'b1;
    repeat (2) @(posedge core_clk);
    deep_stop <= 1'b0;
    ahb(0, 8'h00, 0);
    chk(r, 0);
    chk_pin(pwr, 1'b0);
    chk_pin(oe, 1'b0);
    chk_pin(irq, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
